// ===== inc/mss_defs.vh
// Purpose: constants of the multi segment speed sequencer
// Assumes: 32-bit classic wishbone, byte addresses
// Notes:   frequencies in 0.01 Hz, timers in 0.1 s
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define MSS_OFS_CTRL       8'h00
`define MSS_OFS_RUN_MODE   8'h04
`define MSS_OFS_DIR_LOW    8'h08
`define MSS_OFS_DIR_HIGH   8'h0C
`define MSS_OFS_RAMP_LOW   8'h10
`define MSS_OFS_RAMP_HIGH  8'h14
`define MSS_OFS_STATUS     8'h18
`define MSS_OFS_FREQ_BASE  8'h40
`define MSS_OFS_TIMER_BASE 8'h80
`define MSS_TABLE_SPAN     8'h40

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MSS_CTRL_MODE_LSB  0
`define MSS_CTRL_SRC_BIT   4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MSS_RST_SEG_MODE   3'h2
`define MSS_RST_MAIN_SRC   1'b0
`define MSS_RST_RUN_MODE   2'h0
`define MSS_RST_DIR        8'h00
`define MSS_RST_RAMP       16'h0000
`define MSS_RST_TABLE      16'h0000

// ----------------------------------------------------------------------
// segment modes and run modes
// ----------------------------------------------------------------------
`define MSS_SEG_NORMAL     3'h0
`define MSS_SEG_INTERNAL   3'h1
`define MSS_SEG_EXT_FOUR   3'h2
`define MSS_SEG_EXT_SIXTN  3'h3
`define MSS_SEG_DRAFT      3'h4
`define MSS_SEG_TRAVERSE   3'h5
`define MSS_RUN_ONE_CYCLE  2'h0
`define MSS_RUN_CIRCULAR   2'h1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MSS_CLK_NS         40
`define MSS_TIMER_UNIT_NS  100_000_000
`define MSS_DRAFT_FACTOR   24'h00_000A
`define MSS_GAP_TICKS      1

`endif

// ===== src/mss_sequencer.v
// Purpose: sixteen-speed setpoint sequencer with wishbone register file
// Assumes: clk_i 25 MHz, synchronous active high reset, pins asynchronous
// Notes:   feeds a separate ramp generator; frequency in 0.01 Hz units
//
// Behaviour
// - segment mode 3 takes setpoint from four external select terminals
// - select bit one is lsb; code zero main frequency, code n preset n+1
// - external sixteen-speed mode takes ramp and direction from terminals
// - main source zero means keypad frequency is the main frequency
// - draft mode starts only on the external draft trigger terminal
// - draft actuation lasts ten times the first segment timer
// - after draft run third preset, assert output until stop, then release
// - traverse running ignores all commands except stop, fault, emergency stop
// - traverse uses keypad and second preset, hop eighth preset, timers one two
// - run mode 0..3 picks one-cycle, circular, gapped variants; internal only
// - one-cycle mode steps segments, stops after one cycle, needs new run
// - circular mode repeats forever, ignores all but stop, fault, emergency stop
// - stop-interval modes stop output then restart between segments
// - segment one uses keypad frequency, others presets; own timer each
// - two 8-bit direction masks for segments 1-8 and 9-16, internal only
// - 2-bit ramp selector 00..11 picks first to fourth ramp pair
// - two 16-bit ramp words, segment one bits 1:0, eight bits 15:14
// - segment mode 0 normal, 1 internal program, 2 external four-speed
// - internal program ignores external timing and direction switching
`timescale 1ns/100ps
`include "mss_defs.vh"

module mss_sequencer #(
  parameter FREQ_W      = 16,
  parameter TIMER_W     = 16,
  parameter TICK_CYCLES = `MSS_TIMER_UNIT_NS / `MSS_CLK_NS
) (
  // clock and reset
  input  wire              clk_i,
  input  wire              rst_i,
  // wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [31:0]       wb_dat_i,
  input  wire [3:0]        wb_sel_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  // digital input terminals
  input  wire              run_cmd_i,
  input  wire              stop_cmd_i,
  input  wire              ext_fault_i,
  input  wire              estop_i,
  input  wire [3:0]        speed_sel_i,
  input  wire              ext_reverse_i,
  input  wire [1:0]        ext_ramp_sel_i,
  input  wire              draft_trig_i,
  // main frequency from a non-keypad source
  input  wire [FREQ_W-1:0] main_freq_ext_i,
  // towards the ramp generator
  output reg  [FREQ_W-1:0] freq_set_o,
  output reg               reverse_o,
  output reg  [1:0]        ramp_sel_o,
  output reg               running_o,
  output reg               draft_done_o
);

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam ST_IDLE  = 3'd0;
  localparam ST_RUN   = 3'd1;
  localparam ST_PROG  = 3'd2;
  localparam ST_GAP   = 3'd3;
  localparam ST_DRAFT = 3'd4;
  localparam ST_HOLD  = 3'd5;
  localparam ST_TRAV  = 3'd6;
  localparam CNT_W    = 24;

  // --------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------
  // mask bit order
  function dir_of;
    input [3:0] seg;
    input [7:0] lo;
    input [7:0] hi;
    begin
      dir_of = seg[3] ? hi[seg[2:0]] : lo[seg[2:0]];
    end
  endfunction

  function [1:0] ramp_of;
    input [3:0]  seg;
    input [15:0] lo;
    input [15:0] hi;
    reg   [15:0] w;
    begin
      w = seg[3] ? hi : lo;
      ramp_of = w[{seg[2:0], 1'b0} +: 2];
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    begin
      merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  localparam PIN_W = 12;
  wire [PIN_W-1:0] pin_raw = {draft_trig_i, ext_ramp_sel_i, ext_reverse_i, speed_sel_i,
                              estop_i, ext_fault_i, stop_cmd_i, run_cmd_i};
  reg  [PIN_W-1:0] pin_meta_reg;
  reg  [PIN_W-1:0] pin_sync_reg;
  reg  [PIN_W-1:0] pin_prev_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= {PIN_W{1'b0}};
      pin_sync_reg <= {PIN_W{1'b0}};
      pin_prev_reg <= {PIN_W{1'b0}};
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  wire       run_rise   = pin_sync_reg[0] & ~pin_prev_reg[0];
  wire       halt       = pin_sync_reg[1] | pin_sync_reg[2] | pin_sync_reg[3];
  // select bit one is the lsb
  wire [3:0] sel_code   = pin_sync_reg[7:4];
  wire       ext_rev    = pin_sync_reg[8];
  wire [1:0] ext_ramp   = pin_sync_reg[10:9];
  wire       draft_rise = pin_sync_reg[11] & ~pin_prev_reg[11];

  // --------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------
  reg [2:0]         seg_mode_reg;
  reg               main_src_reg;
  reg [1:0]         run_mode_reg;
  reg [7:0]         dir_low_reg;
  reg [7:0]         dir_high_reg;
  reg [15:0]        ramp_low_reg;
  reg [15:0]        ramp_high_reg;
  // index 0 is the keypad frequency, index n the preset n+1
  reg [FREQ_W-1:0]  freq_reg  [0:15];
  reg [TIMER_W-1:0] timer_reg [0:15];

  reg [2:0]         state_reg;
  reg [3:0]         seg_reg;

  wire       wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wb_wr     = wb_req & wb_we_i;
  wire       in_freq   = (wb_adr_i >= `MSS_OFS_FREQ_BASE) &&
                         (wb_adr_i < `MSS_OFS_FREQ_BASE + `MSS_TABLE_SPAN);
  wire       in_timer  = (wb_adr_i >= `MSS_OFS_TIMER_BASE) &&
                         (wb_adr_i < `MSS_OFS_TIMER_BASE + `MSS_TABLE_SPAN);
  wire [3:0] tbl_idx   = wb_adr_i[5:2];

  always @(posedge clk_i) begin
    if (rst_i) begin
      seg_mode_reg  <= `MSS_RST_SEG_MODE;
      main_src_reg  <= `MSS_RST_MAIN_SRC;
      run_mode_reg  <= `MSS_RST_RUN_MODE;
      dir_low_reg   <= `MSS_RST_DIR;
      dir_high_reg  <= `MSS_RST_DIR;
      ramp_low_reg  <= `MSS_RST_RAMP;
      ramp_high_reg <= `MSS_RST_RAMP;
    end else if (wb_wr && wb_adr_i[1:0] == 2'b00) begin
      case (wb_adr_i)
        `MSS_OFS_CTRL: if (wb_sel_i[0]) begin
          seg_mode_reg <= wb_dat_i[`MSS_CTRL_MODE_LSB +: 3];
          main_src_reg <= wb_dat_i[`MSS_CTRL_SRC_BIT];
        end
        `MSS_OFS_RUN_MODE: if (wb_sel_i[0]) run_mode_reg <= wb_dat_i[1:0];
        `MSS_OFS_DIR_LOW:  if (wb_sel_i[0]) dir_low_reg  <= wb_dat_i[7:0];
        `MSS_OFS_DIR_HIGH: if (wb_sel_i[0]) dir_high_reg <= wb_dat_i[7:0];
        `MSS_OFS_RAMP_LOW:  ramp_low_reg  <= merge16(ramp_low_reg, wb_dat_i, wb_sel_i);
        `MSS_OFS_RAMP_HIGH: ramp_high_reg <= merge16(ramp_high_reg, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_table
      always @(posedge clk_i) begin
        if (rst_i) begin
          freq_reg[gi]  <= `MSS_RST_TABLE;
          timer_reg[gi] <= `MSS_RST_TABLE;
        end else if (wb_wr && wb_adr_i[1:0] == 2'b00 && tbl_idx == gi) begin
          if (in_freq) freq_reg[gi] <= merge16(freq_reg[gi], wb_dat_i, wb_sel_i);
          if (in_timer) timer_reg[gi] <= merge16(timer_reg[gi], wb_dat_i, wb_sel_i);
        end
      end
    end
  endgenerate

  // one wait state; unmapped reads give zero and writes are dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (in_freq) wb_dat_o <= {16'h0000, freq_reg[tbl_idx]};
        else if (in_timer) wb_dat_o <= {16'h0000, timer_reg[tbl_idx]};
        else begin
          case (wb_adr_i)
            `MSS_OFS_CTRL:      wb_dat_o <= {27'h000_0000, main_src_reg, 1'b0, seg_mode_reg};
            `MSS_OFS_RUN_MODE:  wb_dat_o <= {30'h0000_0000, run_mode_reg};
            `MSS_OFS_DIR_LOW:   wb_dat_o <= {24'h00_0000, dir_low_reg};
            `MSS_OFS_DIR_HIGH:  wb_dat_o <= {24'h00_0000, dir_high_reg};
            `MSS_OFS_RAMP_LOW:  wb_dat_o <= {16'h0000, ramp_low_reg};
            `MSS_OFS_RAMP_HIGH: wb_dat_o <= {16'h0000, ramp_high_reg};
            `MSS_OFS_STATUS:    wb_dat_o <= {22'h00_0000, draft_done_o, running_o, seg_reg,
                                             1'b0, state_reg};
            default:            wb_dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // 0.1 s time base
  // --------------------------------------------------------------------
  reg [CNT_W-1:0] tick_cnt_reg;
  wire            tick = (tick_cnt_reg == TICK_CYCLES[CNT_W-1:0] - 1'b1);

  always @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_reg <= {CNT_W{1'b0}};
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  reg [CNT_W-1:0] elapsed_reg;
  reg             hop_reg;

  wire [FREQ_W-1:0] main_freq = main_src_reg ? main_freq_ext_i : freq_reg[0];
  wire [CNT_W-1:0]  seg_time  = {{(CNT_W-TIMER_W){1'b0}}, timer_reg[seg_reg]};
  wire [CNT_W-1:0]  draft_time = {{(CNT_W-TIMER_W){1'b0}}, timer_reg[0]} * `MSS_DRAFT_FACTOR;
  wire              seg_done  = (elapsed_reg >= seg_time);
  wire              last_seg  = (seg_reg == 4'hF);
  // bit 1 adds stop intervals, bit 0 circular
  wire              gapped    = run_mode_reg[1];
  wire              circular  = run_mode_reg[0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      seg_reg     <= 4'h0;
      elapsed_reg <= {CNT_W{1'b0}};
      hop_reg     <= 1'b0;
    end else if (halt) begin
      // stop, fault and emergency stop always win
      state_reg   <= ST_IDLE;
      seg_reg     <= 4'h0;
      elapsed_reg <= {CNT_W{1'b0}};
      hop_reg     <= 1'b0;
    end else begin
      if (tick) elapsed_reg <= elapsed_reg + 1'b1;
      case (state_reg)
        ST_IDLE: begin
          seg_reg     <= 4'h0;
          elapsed_reg <= {CNT_W{1'b0}};
          case (seg_mode_reg)
            // draft waits for its trigger terminal
            `MSS_SEG_DRAFT: if (draft_rise) state_reg <= ST_DRAFT;
            // fresh run command starts the program
            `MSS_SEG_INTERNAL: if (run_rise) state_reg <= ST_PROG;
            `MSS_SEG_TRAVERSE: begin
              if (run_rise) begin
                state_reg <= ST_TRAV;
                hop_reg   <= 1'b1;
              end
            end
            default: if (run_rise) state_reg <= ST_RUN;
          endcase
        end
        ST_PROG: begin
          if (seg_done) begin
            elapsed_reg <= {CNT_W{1'b0}};
            if (last_seg && !circular) begin
              state_reg <= ST_IDLE;
            end else begin
              seg_reg <= seg_reg + 1'b1;
              if (gapped && timer_reg[seg_reg + 1'b1] != {TIMER_W{1'b0}}) begin
                state_reg <= ST_GAP;
              end
            end
          end
        end
        ST_GAP: if (elapsed_reg >= `MSS_GAP_TICKS) begin
          state_reg   <= ST_PROG;
          elapsed_reg <= {CNT_W{1'b0}};
        end
        ST_DRAFT: if (elapsed_reg >= draft_time) state_reg <= ST_HOLD;
        ST_HOLD: state_reg <= ST_HOLD;
        ST_TRAV: begin
          // run and select inputs not looked at here
          if (tick) hop_reg <= 1'b0;
          // timers one and two set the halves
          if (elapsed_reg >= {{(CNT_W-TIMER_W){1'b0}}, timer_reg[seg_reg[0]]}) begin
            seg_reg     <= {3'h0, ~seg_reg[0]};
            elapsed_reg <= {CNT_W{1'b0}};
            hop_reg     <= 1'b1;
          end
        end
        ST_RUN: if (seg_mode_reg == `MSS_SEG_INTERNAL || seg_mode_reg == `MSS_SEG_DRAFT ||
                    seg_mode_reg == `MSS_SEG_TRAVERSE) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // setpoint outputs
  // --------------------------------------------------------------------
  reg [FREQ_W-1:0] freq_next;
  reg              rev_next;
  reg [1:0]        ramp_next;
  reg [FREQ_W:0]   hop_sum;

  always @* begin
    freq_next = {FREQ_W{1'b0}};
    rev_next  = ext_rev;
    ramp_next = ext_ramp;
    hop_sum   = {(FREQ_W+1){1'b0}};
    case (state_reg)
      ST_RUN: freq_next = (seg_mode_reg == `MSS_SEG_EXT_SIXTN && sel_code != 4'h0) ? freq_reg[sel_code] : main_freq;
      ST_PROG, ST_GAP: begin
        freq_next = (state_reg == ST_GAP) ? {FREQ_W{1'b0}} : freq_reg[seg_reg];
        rev_next  = dir_of(seg_reg, dir_low_reg, dir_high_reg);
        ramp_next = ramp_of(seg_reg, ramp_low_reg, ramp_high_reg);
      end
      ST_DRAFT: freq_next = freq_reg[0];
      ST_HOLD:  freq_next = freq_reg[2];
      ST_TRAV: begin
        // turning points keypad and second preset, hop eighth preset
        hop_sum = {1'b0, freq_reg[seg_reg[0]]} + {1'b0, freq_reg[7]};
        if (!hop_reg) freq_next = freq_reg[seg_reg[0]];
        else if (seg_reg[0]) freq_next = hop_sum[FREQ_W] ? {FREQ_W{1'b1}} : hop_sum[FREQ_W-1:0];
        else freq_next = (freq_reg[0] > freq_reg[7]) ? freq_reg[0] - freq_reg[7] : {FREQ_W{1'b0}};
      end
      default: freq_next = {FREQ_W{1'b0}};
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      freq_set_o   <= {FREQ_W{1'b0}};
      reverse_o    <= 1'b0;
      ramp_sel_o   <= 2'b00;
      running_o    <= 1'b0;
      draft_done_o <= 1'b0;
    end else begin
      freq_set_o   <= freq_next;
      reverse_o    <= (state_reg == ST_IDLE) ? 1'b0 : rev_next;
      ramp_sel_o   <= ramp_next;
      running_o    <= (state_reg != ST_IDLE) && (state_reg != ST_GAP);
      draft_done_o <= (state_reg == ST_HOLD) && !halt;
    end
  end

endmodule

// ===== sim/mss_checker.sv
// Purpose: port-level checks of the speed sequencer
// Assumes: mode and table shadows follow acked writes
// Notes:   shadows lag the design one cycle, harmless while idle
`timescale 1ns/100ps
module mss_checker #(
  parameter FREQ_W = 16
) (
  // clock and reset
  input wire              clk_i,
  input wire              rst_i,
  // register bus
  input wire              wb_cyc_i,
  input wire              wb_stb_i,
  input wire              wb_we_i,
  input wire [7:0]        wb_adr_i,
  input wire [31:0]       wb_dat_i,
  input wire [3:0]        wb_sel_i,
  input wire [31:0]       wb_dat_o,
  input wire              wb_ack_o,
  // terminals
  input wire              stop_cmd_i,
  input wire              ext_fault_i,
  input wire              estop_i,
  input wire [3:0]        speed_sel_i,
  input wire              ext_reverse_i,
  input wire [1:0]        ext_ramp_sel_i,
  input wire [FREQ_W-1:0] main_freq_ext_i,
  // setpoint side
  input wire [FREQ_W-1:0] freq_set_o,
  input wire              reverse_o,
  input wire [1:0]        ramp_sel_o,
  input wire              running_o,
  input wire              draft_done_o
);
  reg  [2:0]        mode_q;
  reg               src_q;
  reg  [FREQ_W-1:0] tbl_q [0:15];
  wire              wr    = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  wire              halt  = stop_cmd_i || ext_fault_i || estop_i;
  wire [FREQ_W-1:0] exp_f = (speed_sel_i == 4'h0 && src_q) ? main_freq_ext_i : tbl_q[speed_sel_i];
  wire              ext_m = mode_q == 3'h3 && running_o && !halt;

  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= 3'h2;
      src_q  <= 1'b0;
    end else if (wr && wb_adr_i == 8'h00) begin
      mode_q <= wb_dat_i[2:0];
      src_q  <= wb_dat_i[4];
    end
    if (wr && wb_adr_i[7:6] == 2'b01)
      tbl_q[wb_adr_i[5:2]] <= wb_dat_i[FREQ_W-1:0];
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged after one wait cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside an acknowledge");
  reset_idle_a: assert property ($fell(rst_i) |-> !running_o && !draft_done_o && freq_set_o == 0)
    else $error("outputs not idle after reset");
  halt_stop_a: assert property (halt [*6] |-> !running_o && !draft_done_o)
    else $error("halt input did not stop the drive");
  ext_freq_a: assert property ((ext_m && $stable(speed_sel_i)) [*6] |-> freq_set_o == exp_f)
    else $error("setpoint differs from the selected table entry");
  ext_dir_a: assert property ((ext_m && $stable({ext_reverse_i, ext_ramp_sel_i})) [*6]
    |-> reverse_o == ext_reverse_i && ramp_sel_o == ext_ramp_sel_i)
    else $error("direction or ramp not taken from the terminals");
  draft_hold_a: assert property ($rose(draft_done_o) |-> freq_set_o == tbl_q[2])
    else $error("draft hold frequency wrong");
  draft_keep_a: assert property (draft_done_o && !halt |=> draft_done_o)
    else $error("draft output released without a halt");

  cover property ($rose(draft_done_o));
  cover property (ext_m);
  cover property (wb_ack_o && !wb_we_i);
endmodule

// ===== sim/mss_terminals.sv
// Purpose: digital input terminals feeding the sequencer
// Assumes: driven only from the bench through its tasks
// Notes:   pulses are held long enough for the pin synchroniser
`timescale 1ns/100ps
module mss_terminals (
  // clock
  input  wire       clk_i,
  // terminal pins
  output reg        run_o = 1'b0,
  output reg        stop_o = 1'b0,
  output reg        draft_o = 1'b0,
  output reg  [3:0] sel_o = 4'h0
);
  // 0 run, 1 stop, 2 draft; seven edges so a halt is seen for six
  task pulse(input integer which);
    begin
      @(posedge clk_i);
      run_o   <= which == 0;
      stop_o  <= which == 1;
      draft_o <= which == 2;
      repeat (7) @(posedge clk_i);
      {run_o, stop_o, draft_o} <= 3'b000;
    end
  endtask
  task set_sel(input [3:0] code);
    begin
      @(posedge clk_i);
      sel_o <= code;
    end
  endtask
endmodule

// ===== sim/multi_segment_speed_sequencer_bench.sv
// Purpose: self-checking bench of the speed sequencer
// Assumes: tick shortened to four cycles
// Notes:   run, stop, draft and select terminals come from mss_terminals
`timescale 1ns/100ps
module multi_segment_speed_sequencer_bench;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0, stb = 1'b0, we = 1'b0, fault = 1'b0, estop = 1'b0, erev = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wd = 32'h0000_0000, rd;
  reg  [3:0]  sel = 4'h0, lanes = 4'hF;
  reg  [15:0] mainx = 16'h0000;
  reg  [1:0]  eramp = 2'h0;
  wire [31:0] dato;
  wire        ack, run, stop, drt, runo, rev, done;
  wire [3:0]  ssel;
  wire [1:0]  ramp;
  wire [15:0] freq;
  integer     n_fail = 0, n_checks = 0, cnt = 0, m;
  localparam [15:0] MAINX = 16'h2222;
  localparam [31:0] Z = 32'h0000_0000;

  always #20 clk_i = ~clk_i;

  mss_terminals i_term (.clk_i(clk_i), .run_o(run), .stop_o(stop), .draft_o(drt), .sel_o(ssel));
  mss_sequencer #(.TICK_CYCLES(4)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(dato), .wb_ack_o(ack), .run_cmd_i(run), .stop_cmd_i(stop),
    .ext_fault_i(fault), .estop_i(estop), .speed_sel_i(ssel), .ext_reverse_i(erev),
    .ext_ramp_sel_i(eramp), .draft_trig_i(drt), .main_freq_ext_i(mainx), .freq_set_o(freq),
    .reverse_o(rev), .ramp_sel_o(ramp), .running_o(runo), .draft_done_o(done));

  task results;
    begin
      if (n_fail == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // hang guard, about eight times the expected run
  always @(posedge clk_i) begin
    cnt = cnt + 1;
    if (cnt == 6000) begin
      n_fail = n_fail + 1;
      results;
    end
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, lanes};
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      rd = dato;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
    end
  endtask
  task wf(input [15:0] f);
    integer k;
    for (k = 0; k < 300 && freq !== f; k = k + 1) @(posedge clk_i);
    chk(freq, f);
  endtask
  task wlow;
    integer k;
    for (k = 0; k < 300 && runo !== 1'b0; k = k + 1) @(posedge clk_i);
    chk(runo, 1'b0);
  endtask
  function [15:0] ft(input integer n);
    ft = 16'h1000 + n * 16'h0111;
  endfunction

  task t_regs;
    integer i;
    begin
      wb(0, 8'h00, Z); chk(rd[2:0], 3'h2);
      for (i = 1; i < 6; i = i + 1) begin
        wb(0, {i[5:0], 2'b00}, Z); chk(rd, Z);
        wb(1, {i[5:0], 2'b00}, 32'hFFFF_FFFF);
        wb(0, {i[5:0], 2'b00}, Z); chk(rd, i == 1 ? 32'h3 : i < 4 ? 32'hFF : 32'hFFFF);
      end
      wb(1, 8'h3C, 32'hFFFF_FFFF);
      wb(0, 8'h3C, Z); chk(rd, Z);
      lanes = 4'h2;
      wb(1, 8'h10, 32'h0000_1234);
      lanes = 4'hF;
      wb(0, 8'h10, Z); chk(rd, 32'h0000_12FF);
      wb(1, 8'h08, 32'h0000_0002);
      wb(1, 8'h0C, 32'h0000_0001);
      wb(1, 8'h10, 32'h0000_000D);
      wb(1, 8'h14, 32'h0000_0002);
      wb(1, 8'h80, 32'h0000_0002);
      wb(1, 8'h84, 32'h0000_0002);
      wb(1, 8'hA0, 32'h0000_0002);
      for (i = 0; i < 16; i = i + 1) wb(1, {2'b01, i[3:0], 2'b00}, {16'h0000, ft(i)});
    end
  endtask
  task t_ext;
    integer i;
    begin
      mainx <= MAINX;
      wb(1, 8'h00, 32'h0000_0003);
      {erev, eramp} <= 3'b110;
      i_term.pulse(0); chk(runo, 1'b1);
      for (i = 0; i < 16; i = i + 1) begin
        i_term.set_sel(i[3:0]);
        {erev, eramp} <= i[2:0];
        repeat (6) @(posedge clk_i);
        chk(freq, ft(i));
        chk({rev, ramp}, i[2:0]);
      end
      wb(1, 8'h00, 32'h0000_0013);
      i_term.set_sel(4'h0);
      repeat (6) @(posedge clk_i);
      chk(freq, MAINX);
      i_term.set_sel(4'h5);
      wb(1, 8'h00, 32'h0000_0012);
      repeat (2) @(posedge clk_i);
      chk(freq, MAINX);
      i_term.pulse(1);
    end
  endtask
  // ramp words give 01, 11, 10; masks reverse segments two and nine
  task t_prog(input [1:0] md);
    begin
      wb(1, 8'h00, 32'h0000_0001);
      wb(1, 8'h04, {30'h0, md});
      fork
        i_term.pulse(0);
        begin
          wf(ft(0));
          chk({rev, ramp}, 3'b001);
          if (md[1]) begin
            wlow;
            chk(freq, 16'h0000);
          end
          wf(ft(1)); chk({rev, ramp}, 3'b111);
          wf(ft(8)); chk({rev, ramp}, 3'b110);
          if (md[0]) wf(ft(0));
        end
      join
      if (md[0]) begin
        estop <= 1'b1;
        repeat (8) @(posedge clk_i);
        estop <= 1'b0;
      end else begin
        wlow;
        repeat (30) @(posedge clk_i);
        chk(runo, 1'b0);
      end
    end
  endtask
  task t_draft;
    integer k;
    begin
      wb(1, 8'h00, 32'h0000_0004);
      repeat (20) @(posedge clk_i);
      chk(runo, 1'b0);
      k = 0;
      fork
        i_term.pulse(2);
        while (done !== 1'b1 && k < 200) begin
          @(posedge clk_i);
          k = k + 1;
        end
      join
      chk(k >= 80 && k <= 89, 1'b1);
      chk(freq, ft(2));
      repeat (20) @(posedge clk_i);
      chk(done, 1'b1);
      i_term.pulse(1); chk({runo, done}, 2'b00);
    end
  endtask
  task t_trav;
    begin
      wb(1, 8'h00, 32'h0000_0005);
      fork
        i_term.pulse(0);
        begin
          wf(ft(1) + ft(7));
          wf(ft(1));
          wf(ft(0));
        end
      join
      fault <= 1'b1;
      repeat (8) @(posedge clk_i);
      fault <= 1'b0;
      chk(runo, 1'b0);
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_ext;
    for (m = 0; m < 4; m = m + 1) t_prog(m[1:0]);
    t_draft;
    t_trav;
    results;
  end
endmodule

bind mss_sequencer mss_checker #(.FREQ_W(FREQ_W)) i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .stop_cmd_i, .ext_fault_i, .estop_i, .speed_sel_i,
  .ext_reverse_i, .ext_ramp_sel_i, .main_freq_ext_i, .freq_set_o, .reverse_o, .ramp_sel_o, .running_o,
  .draft_done_o);
